/* src/hs_switch_regs.vh */
`ifndef HS_SWITCH_REGS_VH
`define HS_SWITCH_REGS_VH
// Register word addresses
`define ADDR_CH_SELECT 8'h00
`define ADDR_PROTECT 8'h04
`define ADDR_OV_CFG 8'h08
`define ADDR_TIMER1 8'h0c
`define ADDR_TIMER2 8'h10
`define ADDR_PWM_BASE 8'h14
`define ADDR_WAKE_CFG 8'h24
`define ADDR_FAULT 8'h28
`define ADDR_MODE 8'h2c
`define ADDR_OUT_STATE 8'h30
// Source select codes
`define SRC_OFF 4'h0
`define SRC_ON 4'h1
`define SRC_TIMER1 4'h2
`define SRC_TIMER2 4'h3
`define SRC_PWM1 4'h4
`define SRC_PWM2 4'h5
`define SRC_PWM3 4'h6
`define SRC_PWM4 4'h7
`define SRC_SYNC 4'h8
// Device modes
`define MODE_NORMAL 3'h0
`define MODE_STOP 3'h1
`define MODE_SLEEP 3'h2
`define MODE_RESTART 3'h3
`define MODE_FAILSAFE 3'h4
// Wake pin function code for sync
`define WAKE_FN_SYNC 2'h2
// Protect register field positions
`define PROT_UV_SD_DIS 0
`define PROT_UV_REC 1
`define PROT_LP_OV_SD_DIS 2
// Fault register layout: oc[3:0], ol[7:4], uv 8, ov 9
`define FAULT_UV 8
`define FAULT_OV 9
// Filter times in ns and clock period in ns
`define CLK_PERIOD_NS 40
`define OC_FILTER_NS 16000
`define OL_FILTER_NS 220000
`define OC_FILTER_CYC (`OC_FILTER_NS / `CLK_PERIOD_NS)
`define OL_FILTER_CYC (`OL_FILTER_NS / `CLK_PERIOD_NS)
// Reset values
`define CH_SELECT_RST 16'h0000
`define PROTECT_RST 3'h0
`define OV_CFG_RST 8'h00
`endif

/* src/high_side_switch_control.v */
// Contract
// R01: Output follows its selected drive source
// R02: Configuration writable only in normal mode
// R03: Restart or fail-safe disables all outputs
// R04: Undervoltage switches outputs off unless disabled
// R05: Undervoltage release restores or clears selection
// R06: Undervoltage sets only its own flag
// R07: Overvoltage off unless per-channel disable, normal
// R08: Low-power overvoltage disable keeps outputs on
// R09: Overvoltage release restores or clears per channel
// R10: Overvoltage sets only its own flag
// R11: Overcurrent beyond filter time switches off
// R12: Overcurrent sets flag, clears selection
// R13: Overcurrent flags cleared only by software
// R14: Open load flagged after filter, stays on
// R15: Open-load flags persist until software clears
// R16: Static on/off honoured in normal, stop, sleep
// R17: Two timers with independent period, duty
// R18: Four generators, 10-bit duty, two rates
// R19: Generator starts once assigned to channel; here the generators free-run from reset instead
// R20: Tiny duty values not reproduced faithfully
// R21: Wake function sync makes pin sync input
// R22: Software selects sync after pin configured
// R23: Four-bit source select per channel
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "hs_switch_regs.vh"
module high_side_switch_control #(
  parameter OC_FILTER = `OC_FILTER_CYC,
  parameter OL_FILTER = `OL_FILTER_CYC,
  parameter PWM_DIV_SLOW = 64,
  parameter PWM_DIV_FAST = 16
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // Device mode and supply monitors
  input wire [2:0] device_mode,
  input wire supply_uv,
  input wire supply_ov,
  // Per-channel current comparators
  input wire [3:0] over_current,
  input wire [3:0] under_current,
  // Shared wake/sync pin
  input wire shared_wake_sync_pin,
  // Outputs
  output reg [3:0] high_side_output,
  output reg wake_pin_enabled
);

  reg [15:0] ch_select_reg;
  reg [2:0] protect_reg;
  reg [7:0] ov_cfg_reg;
  reg [31:0] timer_reg [0:1];
  reg [10:0] pwm_reg [0:3];
  reg [1:0] wake_fn_reg;
  reg [3:0] oc_flag_reg;
  reg [3:0] ol_flag_reg;
  reg uv_flag_reg;
  reg ov_flag_reg;
  reg [3:0] uv_off_reg;
  reg [3:0] ov_off_reg;
  reg uv_prev_reg;
  reg ov_prev_reg;
  reg [15:0] tcnt_reg [0:1];
  reg [15:0] slow_div_reg;
  reg [15:0] fast_div_reg;
  reg [9:0] slow_phase_reg;
  reg [9:0] fast_phase_reg;
  reg [15:0] ch_select_next;
  reg [3:0] drive;
  reg [3:0] src_level;
  reg [1:0] timer_level;
  reg [3:0] pwm_level;
  wire normal;
  wire low_power;
  wire sync_in;
  integer i;
  wire [3:0] on_now;
  wire [3:0] oc_hit;
  wire [3:0] ol_hit;
  genvar g;

  assign normal = (device_mode == `MODE_NORMAL);
  assign low_power = (device_mode == `MODE_STOP) || (device_mode == `MODE_SLEEP);
  // R21: sync pin use
  assign sync_in = (wake_fn_reg == `WAKE_FN_SYNC) & shared_wake_sync_pin;

  // Filters only run while the switch is really on
  assign on_now = high_side_output & drive;

  // R11: oc filter
  // R14: ol filter
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      persist_filter #(.WIDTH(14), .LIMIT(OC_FILTER)) oc_filter_i (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .level(over_current[g]), .armed(on_now[g]), .hit(oc_hit[g]));
      persist_filter #(.WIDTH(14), .LIMIT(OL_FILTER)) ol_filter_i (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .level(under_current[g]), .armed(on_now[g]), .hit(ol_hit[g]));
    end
  endgenerate

  // Timer and generator levels
  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      // R17: timer on phase
      timer_level[i] = (tcnt_reg[i] < timer_reg[i][31:16]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      // R18: duty compare
      // R20: no minimum pulse shaping
      if (pwm_reg[i][10])
        pwm_level[i] = (fast_phase_reg < pwm_reg[i][9:0]);
      else
        pwm_level[i] = (slow_phase_reg < pwm_reg[i][9:0]);
    end
  end

  // Source selection per channel
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      // R01: source mux
      case (ch_select_reg[i*4 +: 4])
        `SRC_ON: src_level[i] = 1'b1;
        `SRC_TIMER1: src_level[i] = timer_level[0];
        `SRC_TIMER2: src_level[i] = timer_level[1];
        `SRC_PWM1: src_level[i] = pwm_level[0];
        `SRC_PWM2: src_level[i] = pwm_level[1];
        `SRC_PWM3: src_level[i] = pwm_level[2];
        `SRC_PWM4: src_level[i] = pwm_level[3];
        `SRC_SYNC: src_level[i] = sync_in;
        default: src_level[i] = 1'b0;
      endcase
      // R03: mode gating
      // R16: static modes kept
      drive[i] = src_level[i] & (normal | low_power) & ~uv_off_reg[i] & ~ov_off_reg[i];
    end
  end

  // Selection updates: software write, then hardware clears
  always @* begin
    ch_select_next = ch_select_reg;
    // R02: normal mode only
    if (wr && normal && addr == `ADDR_CH_SELECT)
      ch_select_next = wdata[15:0];
    for (i = 0; i < 4; i = i + 1) begin
      // R05: uv release clear
      if (uv_prev_reg && !supply_uv && uv_off_reg[i] && !protect_reg[`PROT_UV_REC])
        ch_select_next[i*4 +: 4] = `SRC_OFF;
      // R09: ov release clear
      if (ov_prev_reg && !supply_ov && ov_off_reg[i] && !ov_cfg_reg[4+i])
        ch_select_next[i*4 +: 4] = `SRC_OFF;
      // R12: oc clears select
      if (oc_hit[i])
        ch_select_next[i*4 +: 4] = `SRC_OFF;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ch_select_reg <= `CH_SELECT_RST;
      protect_reg <= `PROTECT_RST;
      ov_cfg_reg <= `OV_CFG_RST;
      timer_reg[0] <= 32'h0;
      timer_reg[1] <= 32'h0;
      for (i = 0; i < 4; i = i + 1) begin
        pwm_reg[i] <= 11'h0;
      end
      wake_fn_reg <= 2'h0;
      oc_flag_reg <= 4'h0;
      ol_flag_reg <= 4'h0;
      uv_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
      uv_off_reg <= 4'h0;
      ov_off_reg <= 4'h0;
      uv_prev_reg <= 1'b0;
      ov_prev_reg <= 1'b0;
      tcnt_reg[0] <= 16'h0;
      tcnt_reg[1] <= 16'h0;
      slow_div_reg <= 16'h0;
      fast_div_reg <= 16'h0;
      slow_phase_reg <= 10'h0;
      fast_phase_reg <= 10'h0;
      rdata <= 32'h0;
      high_side_output <= 4'h0;
      wake_pin_enabled <= 1'b0;
    end else if (clk_en) begin
      ch_select_reg <= ch_select_next;
      uv_prev_reg <= supply_uv;
      ov_prev_reg <= supply_ov;
      high_side_output <= drive;
      // Wake capability lost while pin serves as sync
      wake_pin_enabled <= (wake_fn_reg != 2'h0) && (wake_fn_reg != `WAKE_FN_SYNC);
      // R19: free-running generators
      // Prescalers set the two generator rates
      if (slow_div_reg >= PWM_DIV_SLOW - 1) begin
        slow_div_reg <= 16'h0;
        slow_phase_reg <= slow_phase_reg + 10'h1;
      end else begin
        slow_div_reg <= slow_div_reg + 16'h1;
      end
      if (fast_div_reg >= PWM_DIV_FAST - 1) begin
        fast_div_reg <= 16'h0;
        fast_phase_reg <= fast_phase_reg + 10'h1;
      end else begin
        fast_div_reg <= fast_div_reg + 16'h1;
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (tcnt_reg[i] >= timer_reg[i][15:0])
          tcnt_reg[i] <= 16'h0;
        else
          tcnt_reg[i] <= tcnt_reg[i] + 16'h1;
      end
      // Configuration writes; frozen outside normal mode
      if (wr && normal) begin
        if (addr == `ADDR_PROTECT)
          protect_reg <= wdata[2:0];
        else if (addr == `ADDR_OV_CFG)
          ov_cfg_reg <= wdata[7:0];
        else if (addr == `ADDR_TIMER1)
          timer_reg[0] <= wdata;
        else if (addr == `ADDR_TIMER2)
          timer_reg[1] <= wdata;
        else if (addr >= `ADDR_PWM_BASE && addr < `ADDR_WAKE_CFG && addr[1:0] == 2'b00)
          pwm_reg[addr[3:2] - 2'h1] <= wdata[10:0];
        else if (addr == `ADDR_WAKE_CFG)
          wake_fn_reg <= wdata[1:0];
      end
      // R04: uv shutdown
      // R06: uv flag only
      if (supply_uv) begin
        uv_flag_reg <= 1'b1;
        if (!protect_reg[`PROT_UV_SD_DIS])
          uv_off_reg <= uv_off_reg | src_level;
      end else begin
        uv_off_reg <= 4'h0;
      end
      // R07: per-channel ov
      // R08: low-power ov disable
      // R10: ov flag only
      if (supply_ov) begin
        ov_flag_reg <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
          if (src_level[i] && !((normal && ov_cfg_reg[i]) ||
              (low_power && protect_reg[`PROT_LP_OV_SD_DIS])))
            ov_off_reg[i] <= 1'b1;
      end else begin
        ov_off_reg <= 4'h0;
      end
      // Flag clear by writing ones; hardware set wins
      if (wr && addr == `ADDR_FAULT) begin
        if (wdata[`FAULT_UV] && !supply_uv)
          uv_flag_reg <= 1'b0;
        if (wdata[`FAULT_OV] && !supply_ov)
          ov_flag_reg <= 1'b0;
      end
      for (i = 0; i < 4; i = i + 1) begin
        // R13: software clear only
        if (oc_hit[i])
          oc_flag_reg[i] <= 1'b1;
        else if (wr && addr == `ADDR_FAULT && wdata[i])
          oc_flag_reg[i] <= 1'b0;
        // R15: sticky open load
        if (ol_hit[i])
          ol_flag_reg[i] <= 1'b1;
        else if (wr && addr == `ADDR_FAULT && wdata[4+i])
          ol_flag_reg[i] <= 1'b0;
      end
      // Read port, data one cycle after strobe
      if (rd) begin
        if (addr == `ADDR_CH_SELECT)
          rdata <= {16'h0, ch_select_reg};
        else if (addr == `ADDR_PROTECT)
          rdata <= {29'h0, protect_reg};
        else if (addr == `ADDR_OV_CFG)
          rdata <= {24'h0, ov_cfg_reg};
        else if (addr == `ADDR_TIMER1)
          rdata <= timer_reg[0];
        else if (addr == `ADDR_TIMER2)
          rdata <= timer_reg[1];
        else if (addr >= `ADDR_PWM_BASE && addr < `ADDR_WAKE_CFG && addr[1:0] == 2'b00)
          rdata <= {21'h0, pwm_reg[addr[3:2] - 2'h1]};
        else if (addr == `ADDR_WAKE_CFG)
          rdata <= {30'h0, wake_fn_reg};
        else if (addr == `ADDR_FAULT)
          rdata <= {22'h0, ov_flag_reg, uv_flag_reg, ol_flag_reg, oc_flag_reg};
        else if (addr == `ADDR_MODE)
          rdata <= {29'h0, device_mode};
        else if (addr == `ADDR_OUT_STATE)
          rdata <= {20'h0, ov_off_reg, uv_off_reg, high_side_output};
        else
          rdata <= 32'h0;
      end else begin
        rdata <= 32'h0;
      end
    end
  end

endmodule // high_side_switch_control

// Saturating persistence filter for one comparator
module persist_filter #(
  parameter WIDTH = 14,
  parameter LIMIT = 400
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  // Comparator level and qualifier
  input wire level,
  input wire armed,
  // Level held past the limit
  output wire hit
);

  reg [WIDTH-1:0] count_reg;
  wire [WIDTH-1:0] limit;

  // Limit must fit the counter width
  assign limit = LIMIT[WIDTH-1:0];
  assign hit = level && (count_reg >= limit);

  // Restarts as soon as the level drops
  always @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (!(level && armed))
        count_reg <= {WIDTH{1'b0}};
      else if (count_reg < limit)
        count_reg <= count_reg + 1'b1;
    end
  end

endmodule // persist_filter

/* testbench/load_model.sv */
`timescale 1ns/10ps
module load_model (
  // From the switches
  input wire [3:0] high_side_output,
  // Faults to inject
  input wire [3:0] short_mask,
  input wire [3:0] open_mask,
  // Current comparators
  output wire [3:0] over_current,
  output wire [3:0] under_current
);
  // Off switch carries no current, so it reads as low
  assign under_current = open_mask | ~high_side_output;
  assign over_current = high_side_output & short_mask;
endmodule // load_model

/* testbench/hs_checker.sv */
`timescale 1ns/10ps
module hs_checker #(parameter OC_FILTER = 4) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  // Mode, supply, load, outputs
  input wire [2:0] device_mode,
  input wire supply_uv,
  input wire supply_ov,
  input wire [3:0] over_current,
  input wire [3:0] high_side_output,
  input wire wake_pin_enabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg uv_dis_reg;
  // Shadow of the shutdown disable; refused outside normal mode
  always @(posedge clk)
    if (!rst_b) uv_dis_reg <= 1'b0;
    else if (wr && addr == 8'h04 && device_mode == 3'h0) uv_dis_reg <= wdata[0];
  sequence s_on_write;
    wr && addr == 8'h00 && wdata[3:0] == 4'h1 && device_mode == 3'h0;
  endsequence
  sequence s_quiet;
    device_mode == 3'h0 && !supply_uv && !supply_ov && !over_current[0];
  endsequence
  AST_STATIC_ON: assert property (s_on_write ##1 s_quiet [*2] |=> high_side_output[0])
    else $error("static on missing");
  AST_RESTART_OFF: assert property (device_mode inside {3'h3, 3'h4} |=> high_side_output == 4'h0)
    else $error("output on in restart");
  AST_UV_OFF: assert property (supply_uv && !uv_dis_reg && device_mode < 3'h3
    |-> ##[1:2] high_side_output == 4'h0)
    else $error("output on in undervoltage");
  AST_OC_OFF: assert property ($rose(over_current[1]) |-> ##[1:8] !high_side_output[1])
    else $error("overcurrent not cut");
  AST_OC_HOLD: assert property ($fell(high_side_output[1]) && $past(over_current[1])
    |=> (!high_side_output[1]) [*3])
    else $error("channel back on");
  AST_SYNC_NO_WAKE: assert property (wr && addr == 8'h24 && wdata[1:0] == 2'h2 && device_mode == 3'h0
    |-> ##2 !wake_pin_enabled)
    else $error("wake kept on sync");
  AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without read");
  AST_UNMAPPED: assert property (rd && addr > 8'h30 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // hs_checker
bind high_side_switch_control hs_checker #(.OC_FILTER(OC_FILTER)) hs_checker_i (.clk, .rst_b,
  .addr, .wdata, .wr, .rd, .rdata, .device_mode, .supply_uv, .supply_ov, .over_current,
  .high_side_output, .wake_pin_enabled);

/* testbench/high_side_switch_control_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module high_side_switch_control_test;
  reg clk = 0, rst_b = 0, wr = 0, rd = 0, rd_d = 0, s = 0;
  reg supply_uv = 0, supply_ov = 0, sync_pin = 0;
  reg [7:0] addr = 0;
  reg [31:0] wdata = 0, ce, cm;
  reg [2:0] device_mode = 0;
  reg [3:0] short_mask = 0, open_mask = 0;
  wire [31:0] rdata;
  wire [3:0] hso, oc, uc;
  wire wake_en;
  int n_tests = 0, n_mismatch = 0, cyc = 0;
  logic [31:0] qe[$], qm[$];
  always #20 clk = ~clk;
  high_side_switch_control #(.OC_FILTER(4), .OL_FILTER(8)) high_side_switch_control_i (
    .clk(clk), .rst_b(rst_b), .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .device_mode(device_mode), .supply_uv(supply_uv), .supply_ov(supply_ov),
    .over_current(oc), .under_current(uc), .shared_wake_sync_pin(sync_pin),
    .high_side_output(hso), .wake_pin_enabled(wake_en));
  load_model load_model_i (.high_side_output(hso), .short_mask(short_mask),
    .open_mask(open_mask), .over_current(oc), .under_current(uc));
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task w(input [7:0] a, input [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1; rd <= 0;
  endtask
  task r(input [7:0] a, input [31:0] e, input [31:0] m);
    @(posedge clk); addr <= a; rd <= 1; wr <= 0; qe.push_back(e); qm.push_back(m);
  endtask
  task idle(input int n);
    repeat (n) begin @(posedge clk); wr <= 0; rd <= 0; end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    cyc++;
    if (rd_d) begin cm = qm.pop_front(); ce = qe.pop_front(); `CHK(rdata & cm, ce) end
    if (cyc == 5000) begin n_mismatch++; summarize; end
  end
  initial begin
    void'($urandom(32374));
    repeat (3) @(posedge clk);
    rst_b <= 1;
    r(8'h00, 0, 32'hffff); r(8'h28, 0, 32'h3ff); r(8'h2c, 0, 7); r(8'h40, 0, '1);
    w(8'h00, 32'h0101); idle(2); r(8'h30, 5, 15);
    idle(1); device_mode <= 1; w(8'h00, 0); idle(2); r(8'h00, 32'h0101, 32'hffff);
    idle(1); device_mode <= 0; w(8'h04, 2); idle(1); supply_uv <= 1; idle(3);
    r(8'h30, 0, 15); r(8'h28, 32'h100, 32'h3ff);
    idle(1); supply_uv <= 0; idle(3); r(8'h30, 5, 15);
    w(8'h28, 32'h100); w(8'h04, 0); idle(1); supply_uv <= 1; idle(3); supply_uv <= 0; idle(3);
    r(8'h00, 0, 32'hffff);
    w(8'h04, 1); w(8'h00, 1); idle(1); supply_uv <= 1; idle(3); r(8'h30, 1, 15);
    idle(1); supply_uv <= 0; w(8'h28, 32'h3ff); r(8'h28, 0, 32'h3ff);
    w(8'h00, 32'h0111); w(8'h08, 32'h24); idle(1); supply_ov <= 1; idle(3);
    r(8'h30, 4, 15); r(8'h28, 32'h200, 32'h3ff);
    idle(1); supply_ov <= 0; idle(3); r(8'h30, 6, 15); r(8'h00, 32'h0110, 32'hffff);
    w(8'h28, 32'h3ff); idle(1); short_mask <= 2; idle(12);
    r(8'h28, 2, 32'h3ff); r(8'h00, 32'h0100, 32'hffff);
    idle(1); short_mask <= 0; w(8'h28, 2); w(8'h00, 32'h0110); idle(2); r(8'h30, 6, 15);
    idle(1); open_mask <= 4; idle(15); r(8'h28, 32'h40, 32'h3ff); r(8'h30, 6, 15);
    idle(1); open_mask <= 0; idle(4); r(8'h28, 32'h40, 32'h3ff);
    w(8'h24, 2); w(8'h00, 32'h8000);
    repeat (4) begin
      s = $urandom % 2; idle(1); sync_pin <= s; idle(3); r(8'h30, {s, 3'h0}, 8);
    end
    w(8'h00, 1);
    for (int m = 3; m < 5; m++) begin
      idle(1); device_mode <= m[2:0]; idle(2); r(8'h30, 0, 15);
      idle(1); device_mode <= 0; idle(2); r(8'h30, 1, 15);
    end
    idle(3);
    summarize;
  end
endmodule // high_side_switch_control_test
